//--- core/pbc_crc_step.sv
// one-byte residue update for a reflected 16-bit crc
`timescale 1ns/1ps
`default_nettype none
module pbc_crc_step #(
	parameter logic [15:0] POLY = 16'ha001
) (
	// operands
	input wire logic [7:0] i_data,
	input wire logic [15:0] i_res,
	// result
	output logic [15:0] o_res
);
	import pbc_pkg::*;

	// data enters low-order bit first, matching the line bit order
	always_comb begin
		logic [15:0] acc;
		acc = i_res ^ {8'h00, i_data};
		for (int k = 0; k < BYTE_W; k++) begin
			if (acc[0]) begin
				acc = (acc >> 1) ^ POLY;
			end else begin
				acc = acc >> 1;
			end
		end
		o_res = acc;
	end
endmodule : pbc_crc_step
`default_nettype wire

//--- core/pbc_process_byte.sv
// process-byte check unit: crc / longitudinal xor residue update
// Behaviour
// - data byte is first operand low byte
// - selector byte picks BISYNC, SDLC or xor
// - BISYNC crc, x16+x15+x2+1
// - SDLC crc, x16+x12+x5+1
// - xor check: residue xor data byte
// - memory form reads residue halfword at address
// - memory form writes result to same halfword
// - register form residue from second operand low half
// - register form result into low half
// - other first operand bytes are ignored
// - first operand register never written
// - condition code never altered
`timescale 1ns/1ps
`default_nettype none
module pbc_process_byte #(
	parameter int ADDR_W = 24
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// instruction request from execute logic
	input wire logic i_start,
	input wire logic i_mem_form,
	input wire logic [pbc_pkg::WORD_W-1:0] i_first_reg_operand,
	input wire logic [pbc_pkg::WORD_W-1:0] i_second_reg_operand,
	input wire logic [ADDR_W-1:0] i_operand_addr,
	// completion and register write-back
	output logic o_busy,
	output logic o_done,
	output logic o_reg_we,
	output logic [pbc_pkg::WORD_W-1:0] o_reg_wdata,
	output logic o_cc_we,
	// halfword memory port
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [pbc_pkg::RES_W-1:0] o_mem_wdata,
	input wire logic [pbc_pkg::RES_W-1:0] i_mem_rdata,
	input wire logic i_mem_ack
);
	import pbc_pkg::*;

	pbc_state_t state_r;
	logic form_mem_r;
	logic [7:0] data_r;
	logic [7:0] sel_r;
	logic [15:0] res_r;
	logic [15:0] hi_r;
	logic [15:0] res_nxt;
	logic [15:0] crc_bisync;
	logic [15:0] crc_sdlc;
	logic take;
	logic busy_r;
	logic done_r;
	logic reg_we_r;
	logic [31:0] reg_wdata_r;
	logic mem_rd_r;
	logic mem_wr_r;
	logic [ADDR_W-1:0] mem_addr_r;
	logic [15:0] mem_wdata_r;

	assign take = i_start && !busy_r;

	pbc_crc_step #(
		.POLY(POLY_BISYNC)
	) u_bisync (
		.i_data(data_r),
		.i_res(res_r),
		.o_res(crc_bisync)
	);

	pbc_crc_step #(
		.POLY(POLY_SDLC)
	) u_sdlc (
		.i_data(data_r),
		.i_res(res_r),
		.o_res(crc_sdlc)
	);

	// undefined selectors leave the residue as it was; software must avoid them
	always_comb begin
		unique case (sel_r)
			SEL_BISYNC: res_nxt = crc_bisync;
			SEL_SDLC: res_nxt = crc_sdlc;
			SEL_XOR: res_nxt = res_r ^ {8'h00, data_r};
			default: res_nxt = res_r;
		endcase
	end

	// operand capture: of the first operand only the data and selector bytes are kept
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			form_mem_r <= 1'b0;
			data_r <= BYTE_RST;
			sel_r <= BYTE_RST;
			hi_r <= RES_RST;
		end else if (take) begin
			form_mem_r <= i_mem_form;
			data_r <= i_first_reg_operand[DATA_MSB:DATA_LSB];
			sel_r <= i_first_reg_operand[SEL_MSB:SEL_LSB];
			hi_r <= i_second_reg_operand[HI_MSB:HI_LSB];
		end
	end

	// sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_r <= PBC_IDLE;
		end else begin
			unique case (state_r)
				PBC_IDLE: begin
					if (take) begin
						state_r <= i_mem_form ? PBC_RD : PBC_CALC;
					end
				end
				PBC_RD: begin
					if (i_mem_ack) begin
						state_r <= PBC_CALC;
					end
				end
				PBC_CALC: begin
					state_r <= form_mem_r ? PBC_WR : PBC_IDLE;
				end
				PBC_WR: begin
					if (i_mem_ack) begin
						state_r <= PBC_IDLE;
					end
				end
				default: state_r <= PBC_IDLE;
			endcase
		end
	end

	// working residue
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			res_r <= RES_RST;
		end else if (take && !i_mem_form) begin
			res_r <= i_second_reg_operand[RES_MSB:RES_LSB];
		end else if (state_r == PBC_RD && i_mem_ack) begin
			res_r <= i_mem_rdata;
		end else if (state_r == PBC_CALC) begin
			res_r <= res_nxt;
		end
	end

	// busy covers the whole instruction, so a second start waits
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			busy_r <= 1'b0;
		end else if (take) begin
			busy_r <= 1'b1;
		end else if (done_r) begin
			busy_r <= 1'b0;
		end
	end

	// completion pulse and register write-back; only the second operand is written
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			done_r <= 1'b0;
			reg_we_r <= 1'b0;
			reg_wdata_r <= WORD_RST;
		end else begin
			done_r <= (state_r == PBC_CALC && !form_mem_r) || (state_r == PBC_WR && i_mem_ack);
			reg_we_r <= state_r == PBC_CALC && !form_mem_r;
			if (state_r == PBC_CALC && !form_mem_r) begin
				reg_wdata_r <= {hi_r, res_nxt};
			end
		end
	end

	// memory requests are levels held until acknowledged
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_addr_r <= '0;
			mem_wdata_r <= RES_RST;
		end else begin
			if (take && i_mem_form) begin
				mem_rd_r <= 1'b1;
				mem_addr_r <= i_operand_addr;
				mem_addr_r[HALF_ALIGN_BIT] <= 1'b0;
			end else if (state_r == PBC_RD && i_mem_ack) begin
				mem_rd_r <= 1'b0;
			end
			if (state_r == PBC_CALC && form_mem_r) begin
				mem_wr_r <= 1'b1;
				mem_wdata_r <= res_nxt;
			end else if (state_r == PBC_WR && i_mem_ack) begin
				mem_wr_r <= 1'b0;
			end
		end
	end

	assign o_busy = busy_r;
	assign o_done = done_r;
	assign o_reg_we = reg_we_r;
	assign o_reg_wdata = reg_wdata_r;
	// flags are never touched by this unit
	assign o_cc_we = 1'b0;
	assign o_mem_rd = mem_rd_r;
	assign o_mem_wr = mem_wr_r;
	assign o_mem_addr = mem_addr_r;
	assign o_mem_wdata = mem_wdata_r;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_xor_reg;
		take && !i_mem_form && i_first_reg_operand[SEL_MSB:SEL_LSB] == SEL_XOR
			|-> ##2 o_reg_we && o_reg_wdata[15:0] ==
			($past(i_second_reg_operand[15:0], 2) ^ {8'h00, $past(i_first_reg_operand[7:0], 2)});
	endproperty
	a_xor_reg: assert property (p_xor_reg) else $error("xor residue wrong");

	property p_hi_kept;
		take && !i_mem_form |-> ##2 o_reg_wdata[31:16] == $past(i_second_reg_operand[31:16], 2);
	endproperty
	a_hi_kept: assert property (p_hi_kept) else $error("second operand high half changed");

	property p_sdlc_example;
		take && !i_mem_form && i_first_reg_operand[23:0] == 24'h01007a &&
			i_second_reg_operand[15:0] == 16'hd053 |-> ##2 o_reg_wdata[15:0] == 16'hbc13;
	endproperty
	a_sdlc_example: assert property (p_sdlc_example) else $error("sdlc example mismatch");

	property p_bisync_one;
		take && !i_mem_form && i_first_reg_operand[23:0] == 24'h000001 &&
			i_second_reg_operand[15:0] == 16'h0000 |-> ##2 o_reg_wdata[15:0] == 16'hc0c1;
	endproperty
	a_bisync_one: assert property (p_bisync_one) else $error("bisync residue wrong");

	property p_ignore_bytes;
		take && !i_mem_form && i_first_reg_operand[SEL_MSB:SEL_LSB] == SEL_SDLC &&
			i_first_reg_operand[7:0] == 8'h7a && i_first_reg_operand[31:24] == 8'hff &&
			i_first_reg_operand[15:8] == 8'hff && i_second_reg_operand[15:0] == 16'hd053
			|-> ##2 o_reg_wdata[15:0] == 16'hbc13;
	endproperty
	a_ignore_bytes: assert property (p_ignore_bytes) else $error("ignored bytes affect result");

	property p_rd_addr;
		take && i_mem_form |=> o_mem_rd && !o_mem_wr &&
			o_mem_addr == {$past(i_operand_addr[ADDR_W-1:1]), 1'b0};
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");

	property p_wr_same;
		$rose(o_mem_wr) |-> $stable(o_mem_addr) && !o_mem_rd;
	endproperty
	a_wr_same: assert property (p_wr_same) else $error("write address moved");

	property p_mem_lrc;
		o_mem_rd && i_mem_ack && sel_r == SEL_XOR
			|-> ##2 o_mem_wr && o_mem_wdata == ($past(i_mem_rdata, 2) ^ {8'h00, data_r});
	endproperty
	a_mem_lrc: assert property (p_mem_lrc) else $error("memory xor result wrong");

	property p_no_cc;
		!o_cc_we && !(o_reg_we && o_mem_wr);
	endproperty
	a_no_cc: assert property (p_no_cc) else $error("condition code or stray write");

	property p_reg_done;
		take && !i_mem_form |-> ##2 o_done && o_reg_we ##1 !o_done && !o_busy;
	endproperty
	a_reg_done: assert property (p_reg_done) else $error("register form timing wrong");

	c_reg_form: cover property (o_done && o_reg_we);
	c_mem_form: cover property ($fell(o_mem_wr) && o_done);
	c_sdlc: cover property (take && i_first_reg_operand[SEL_MSB:SEL_LSB] == SEL_SDLC);
	c_mem_xor: cover property (take && i_mem_form && i_first_reg_operand[SEL_MSB:SEL_LSB] == SEL_XOR);
endmodule : pbc_process_byte
`default_nettype wire

//--- inc/pbc_pkg.sv
// shared constants and types for the process-byte check unit
package pbc_pkg;
	// widths
	localparam int WORD_W = 32;
	localparam int RES_W = 16;
	localparam int BYTE_W = 8;
	// field positions in the first operand register (bit 0 is the low-order end)
	localparam int DATA_LSB = 0;
	localparam int DATA_MSB = 7;
	localparam int SEL_LSB = 16;
	localparam int SEL_MSB = 23;
	// field positions in the second operand register
	localparam int RES_LSB = 0;
	localparam int RES_MSB = 15;
	localparam int HI_LSB = 16;
	localparam int HI_MSB = 31;
	// check-code selector values
	localparam logic [7:0] SEL_BISYNC = 8'h00;
	localparam logic [7:0] SEL_SDLC = 8'h01;
	localparam logic [7:0] SEL_XOR = 8'h02;
	// generator polynomials, bit-reversed for low-order-bit-first shifting
	localparam logic [15:0] POLY_BISYNC = 16'ha001;
	localparam logic [15:0] POLY_SDLC = 16'h8408;
	// reset values
	localparam logic [15:0] RES_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// residue halfword must sit on an even byte address
	localparam int HALF_ALIGN_BIT = 0;
	// sequencer states
	typedef enum logic [2:0] {
		PBC_IDLE,
		PBC_RD,
		PBC_CALC,
		PBC_WR
	} pbc_state_t;
endpackage : pbc_pkg

//--- verification/pbc_mem_model.sv
// behavioural halfword storage answering the unit's rd/wr/ack handshake
`timescale 1ns/1ps
`default_nettype none
module pbc_mem_model (
	// clock, reset and answer delay
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [3:0] i_wait,
	// preload from the bench, only while the unit is idle
	input wire logic i_load,
	input wire logic [3:0] i_load_idx,
	input wire logic [15:0] i_load_data,
	// request side
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [23:0] i_addr,
	input wire logic [15:0] i_wdata,
	// answer side
	output logic [15:0] o_rdata,
	output logic o_ack
);
	logic [15:0] mem [0:15];
	logic [3:0] cnt_r;
	logic hit;
	assign hit = i_rstn && !o_ack && (i_rd || i_wr) && (cnt_r == i_wait);
	// outside an ack the read data keeps toggling so stale values never look valid
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_ack <= 1'b0;
			cnt_r <= 4'h0;
			o_rdata <= 16'h5a5a;
		end else if (o_ack || !(i_rd || i_wr)) begin
			o_ack <= 1'b0;
			cnt_r <= 4'h0;
			o_rdata <= ~o_rdata;
		end else if (cnt_r == i_wait) begin
			o_ack <= 1'b1;
			if (i_rd) begin
				o_rdata <= mem[i_addr[4:1]];
			end
		end else begin
			cnt_r <= cnt_r + 4'h1;
			o_rdata <= ~o_rdata;
		end
	end
	// storage has one writer: the preload wins, the unit's write lands with its ack
	always_ff @(posedge i_clk) begin
		if (i_load) begin
			mem[i_load_idx] <= i_load_data;
		end else if (hit && i_wr) begin
			mem[i_addr[4:1]] <= i_wdata;
		end
	end
endmodule : pbc_mem_model
`default_nettype wire

//--- verification/pbc_process_byte_tb_top.sv
// self-checking bench for the process-byte check unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pbc_process_byte_tb_top;
	import pbc_pkg::*;
	localparam logic [23:0] ADDR = 24'h00100c;
	logic clk, rstn, start, mem_form, o_busy, o_done, o_reg_we, o_cc_we;
	logic o_mem_rd, o_mem_wr, mem_ack, mem_load;
	logic [31:0] first_op, second_op, o_reg_wdata;
	logic [23:0] o_mem_addr;
	logic [15:0] o_mem_wdata, mem_rdata, load_data;
	logic [3:0] mem_wait;
	int err_count = 0;
	int total_checks = 0;
	pbc_process_byte #(.ADDR_W(24)) u_dut (.i_clk(clk), .i_rstn(rstn), .i_start(start),
		.i_mem_form(mem_form), .i_first_reg_operand(first_op),
		.i_second_reg_operand(second_op), .i_operand_addr(ADDR), .o_busy(o_busy),
		.o_done(o_done), .o_reg_we(o_reg_we), .o_reg_wdata(o_reg_wdata), .o_cc_we(o_cc_we),
		.o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .i_mem_rdata(mem_rdata), .i_mem_ack(mem_ack));
	pbc_mem_model u_mem (.i_clk(clk), .i_rstn(rstn), .i_wait(mem_wait), .i_load(mem_load),
		.i_load_idx(ADDR[4:1]), .i_load_data(load_data), .i_rd(o_mem_rd),
		.i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(mem_rdata),
		.o_ack(mem_ack));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic print_verdict();
		if (err_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	// reflected shift, data low-order bit first
	function automatic logic [15:0] ref_res(input logic [7:0] sel, input logic [7:0] d,
		input logic [15:0] r);
		logic [15:0] p;
		p = (sel == SEL_SDLC) ? POLY_SDLC : POLY_BISYNC;
		if (sel == SEL_XOR) begin
			return r ^ {8'h00, d};
		end
		for (int i = 0; i < 8; i++) begin
			r = (r >> 1) ^ ((r[0] ^ d[i]) ? p : 16'h0000);
		end
		return r;
	endfunction : ref_res
	// start held over a busy edge too, so the second request must be ignored
	task automatic run_reg(input logic [7:0] sel, input logic [7:0] d, input logic [15:0] r,
		input logic [15:0] pad);
		int n;
		n = 0;
		first_op = {pad[15:8], sel, pad[7:0], d};
		second_op = {16'h0000, r};
		mem_form = 1'b0;
		start = 1'b1;
		@(negedge clk);
		@(negedge clk);
		start = 1'b0;
		while (o_done !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		`CHK(n, 0)
		`CHK(o_reg_we, 1'b1)
		`CHK(o_reg_wdata, {16'h0000, ref_res(sel, d, r)})
		`CHK(o_cc_we, 1'b0)
		@(negedge clk);
		`CHK({o_busy, o_done}, 2'b00)
	endtask : run_reg
	task automatic run_mem(input logic [7:0] sel, input logic [7:0] d, input logic [15:0] r,
		input logic [15:0] e, input logic [3:0] w);
		int n;
		n = 0;
		mem_load = 1'b1;
		load_data = r;
		@(negedge clk);
		mem_load = 1'b0;
		mem_wait = w;
		first_op = {8'h5a, sel, 8'hc3, d};
		second_op = 32'hffff_ffff;
		mem_form = 1'b1;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		while (o_done !== 1'b1 && n < 40) begin
			if (o_mem_rd === 1'b1 || o_mem_wr === 1'b1) `CHK(o_mem_addr, ADDR)
			@(negedge clk);
			n++;
		end
		`CHK(o_done, 1'b1)
		`CHK(u_mem.mem[ADDR[4:1]], e)
		`CHK({o_reg_we, o_cc_we}, 2'b00)
		@(negedge clk);
	endtask : run_mem
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		mem_form = 1'b0;
		first_op = 32'h0000_0000;
		second_op = 32'h0000_0000;
		mem_wait = 4'h0;
		mem_load = 1'b0;
		load_data = 16'h0000;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		`CHK({o_busy, o_mem_rd, o_mem_wr}, 3'b000)
		run_mem(SEL_SDLC, 8'h7a, 16'hd053, 16'hbc13, 4'h0);
		run_reg(SEL_SDLC, 8'h7a, 16'hd053, 16'h0000);
		run_reg(SEL_SDLC, 8'h7a, 16'hd053, 16'hffff);
		run_reg(SEL_BISYNC, 8'h01, 16'h0000, 16'h0000);
		// only the three defined selectors are ever supplied
		for (int s = 0; s < 3; s++) begin
			run_reg(s[7:0], 8'h96, 16'h1d0f, 16'ha53c);
			run_reg(s[7:0], 8'h01, 16'h0000, 16'ha53c);
			run_mem(s[7:0], 8'he4, 16'h4b2c, ref_res(s[7:0], 8'he4, 16'h4b2c), 4'h3);
		end
		print_verdict();
	end
	initial begin
		#(40 * 3000);
		err_count++;
		print_verdict();
	end
endmodule : pbc_process_byte_tb_top
`default_nettype wire
